// ---- rtl/ext_arith_regs.svh ----
// Constants for the extended integer arithmetic unit
`ifndef EXT_ARITH_REGS_SVH
`define EXT_ARITH_REGS_SVH
`define OPC_HI 15
`define OPC_LO 9
`define DST_HI 8
`define DST_LO 6
`define MODE_HI 5
`define MODE_LO 3
`define SRC_HI 2
`define SRC_LO 0
`define OPC_MUL 7'h38
`define OPC_DIV 7'h39
`define OPC_ASH 7'h3A
`define OPC_DOUBLE_WORD_SHIFT_INSTR 7'h3B
`define CNT_W 6
`define SIGN_BIT 15
`endif

// ---- rtl/ext_arith_pkg.sv ----
// Types for the extended integer arithmetic unit
package ext_arith_pkg;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_MUL,
		OP_DIV,
		OP_ASH,
		OP_DOUBLE_WORD_SHIFT_INSTR
	} op_kind_t;
	typedef struct packed {
		logic [6:0] opcode;
		logic [2:0] dest_reg_field;
		logic [2:0] src_mode;
		logic [2:0] src_spec_field;
	} instr_fields_t;
	typedef struct packed {
		logic n;
		logic z;
		logic v;
		logic c;
	} flags_t;
	typedef struct packed {
		logic hi_we;
		logic [2:0] hi_idx;
		logic [15:0] hi_data;
		logic lo_we;
		logic [2:0] lo_idx;
		logic [15:0] lo_data;
	} writeback_t;
endpackage

// ---- rtl/ext_arith_unit.sv ----
// Extended integer arithmetic unit: multiply, divide and arithmetic shifts
`timescale 1ns/100ps
`include "ext_arith_regs.svh"

// What this block does
// - Split instruction into opcode, destination, source mode and source register fields
// - Recognise opcodes 070 multiply, 071 divide, 072 shift, 073 double shift
// - Shift count is low six source bits, signed; positive left, zero no change
// - Single shift sets N,Z from result, V on left sign change, C last out
// - Double shift joins register high and odd partner low, same count rule
// - Double shift on odd register rotates right that word up to 16
// - Double shift flags N,Z from 32-bit result, V on sign change, C last out
// - Multiply signed 16-bit; even destination gets pair, odd only low half
// - Multiply sets N,Z from product, clears V, C when below -32768 or at least 32767
// - Divide 32-bit pair by 16-bit source; quotient to register, remainder partner
// - Remainder has the dividend's sign unless it is zero
// - Divide overflow and abort when quotient needs more than 16 bits
// - Zero divisor sets V and C; nonzero divisor clears C
// - Divide sets N if quotient negative, Z if quotient zero
// - Bit 15 of a word, or of the high word, is the sign
// - Operands come from host registers or memory; results go to general registers
module ext_arith_unit
	import ext_arith_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Request from the host decoder
	input wire logic start,
	input wire logic [15:0] instr_word,
	input wire logic [15:0] src_operand,
	input wire logic [15:0] dest_value,
	input wire logic [15:0] partner_value,
	// Results toward the host register file and flags
	output logic done,
	output logic illegal_op,
	output writeback_t wb,
	output flags_t flags
);
	instr_fields_t f;
	op_kind_t kind;
	logic [2:0] partner_idx;
	logic signed [15:0] rd_s;
	logic signed [15:0] src_s;
	logic signed [31:0] product;
	logic signed [31:0] dividend;
	logic [31:0] dvd_mag;
	logic [15:0] dvs_mag;
	logic [31:0] quo_mag;
	logic [31:0] rem_mag;
	logic signed [31:0] quo_s;
	logic [15:0] rem_s;
	logic div_ovf;
	logic div_zero;
	logic signed [5:0] cnt;
	logic [5:0] amt;
	logic cnt_neg;
	logic [31:0] sh_in;
	logic [63:0] ext_in;
	logic [63:0] left_v;
	// One bit wider than the input so the last bit shifted out lands in bit 0
	logic [64:0] right_v;
	logic [31:0] sh_res;
	logic sh_carry;
	logic sh_ovf;
	logic [31:0] rot_v;
	writeback_t wb_next;
	flags_t flags_next;

	assign f = instr_fields_t'(instr_word);
	assign partner_idx = f.dest_reg_field | 3'h1;
	assign rd_s = dest_value;
	assign src_s = src_operand;

	// Opcode decode
	always_comb begin
		unique case (f.opcode)
			`OPC_MUL: kind = OP_MUL;
			`OPC_DIV: kind = OP_DIV;
			`OPC_ASH: kind = OP_ASH;
			`OPC_DOUBLE_WORD_SHIFT_INSTR: kind = OP_DOUBLE_WORD_SHIFT_INSTR;
			default: kind = OP_NONE;
		endcase
	end

	// Multiply
	assign product = 32'(rd_s) * 32'(src_s);

	// Divide by magnitudes, then restore signs
	assign dividend = {dest_value, partner_value};
	assign dvd_mag = dividend[31] ? 32'(-dividend) : 32'(dividend);
	assign dvs_mag = src_s[15] ? 16'(-src_s) : 16'(src_s);
	assign div_zero = (src_operand == 16'h0000);
	assign quo_mag = div_zero ? 32'h0 : dvd_mag / {16'h0000, dvs_mag};
	assign rem_mag = div_zero ? 32'h0 : dvd_mag % {16'h0000, dvs_mag};
	assign quo_s = (dividend[31] ^ src_s[15]) ? 32'(-quo_mag) : 32'(quo_mag);
	assign rem_s = dividend[31] ? 16'(-rem_mag) : rem_mag[15:0];
	// Signed range check on the quotient catches register magnitude beyond source
	assign div_ovf = div_zero || (quo_s > 32'sh7FFF) || (quo_s < -32'sh8000);

	// Shifts: one barrel path serves both widths
	assign cnt = src_operand[5:0];
	assign cnt_neg = cnt[5];
	assign amt = cnt_neg ? 6'(-cnt) : 6'(cnt);
	assign sh_in = (kind == OP_DOUBLE_WORD_SHIFT_INSTR) ? {dest_value, partner_value} : {{16{dest_value[15]}}, dest_value};
	assign ext_in = {{32{sh_in[31]}}, sh_in};
	assign left_v = ext_in << amt;
	assign right_v = {ext_in, 1'b0} >> amt;
	assign rot_v = {dest_value, dest_value} >> amt[4:0];

	always_comb begin
		sh_res = sh_in;
		sh_carry = 1'b0;
		sh_ovf = 1'b0;
		if (amt == 6'h00) begin
			sh_res = sh_in;
		end else if (!cnt_neg) begin
			if (kind == OP_DOUBLE_WORD_SHIFT_INSTR) begin
				sh_res = left_v[31:0];
				sh_carry = left_v[32];
				sh_ovf = left_v[31] != sh_in[31];
			end else begin
				sh_res = {{16{left_v[15]}}, left_v[15:0]};
				sh_carry = left_v[16];
				sh_ovf = left_v[15] != sh_in[15];
			end
		end else if (kind == OP_DOUBLE_WORD_SHIFT_INSTR && f.dest_reg_field[0]) begin
			// Odd register: partner is itself, so the shift wraps round
			sh_res = {rot_v[15:0], rot_v[15:0]};
			sh_carry = rot_v[15];
		end else begin
			sh_res = right_v[32:1];
			sh_carry = right_v[0];
		end
	end

	// Next writeback and flags
	always_comb begin
		wb_next = '0;
		flags_next = flags;
		wb_next.hi_idx = f.dest_reg_field;
		wb_next.lo_idx = partner_idx;
		unique case (kind)
			OP_MUL: begin
				if (f.dest_reg_field[0]) begin
					wb_next.hi_we = 1'b1;
					wb_next.hi_data = product[15:0];
				end else begin
					wb_next.hi_we = 1'b1;
					wb_next.hi_data = product[31:16];
					wb_next.lo_we = 1'b1;
					wb_next.lo_data = product[15:0];
				end
				flags_next.n = product[31];
				flags_next.z = (product == 32'sh0);
				flags_next.v = 1'b0;
				flags_next.c = (product < -32'sh8000) || (product >= 32'sh7FFF);
			end
			OP_DIV: begin
				flags_next.v = div_ovf;
				flags_next.c = div_zero;
				flags_next.n = quo_s[15];
				flags_next.z = (quo_s[15:0] == 16'h0000);
				if (!div_ovf) begin
					wb_next.hi_we = 1'b1;
					wb_next.hi_data = quo_s[15:0];
					wb_next.lo_we = 1'b1;
					wb_next.lo_data = rem_s;
				end
				// On abort both write enables stay low
			end
			OP_ASH: begin
				wb_next.hi_we = 1'b1;
				wb_next.hi_data = sh_res[15:0];
				flags_next.n = sh_res[`SIGN_BIT];
				flags_next.z = (sh_res[15:0] == 16'h0000);
				flags_next.v = sh_ovf;
				flags_next.c = sh_carry;
			end
			OP_DOUBLE_WORD_SHIFT_INSTR: begin
				wb_next.hi_we = 1'b1;
				wb_next.hi_data = sh_res[31:16];
				wb_next.lo_we = !f.dest_reg_field[0];
				wb_next.lo_data = sh_res[15:0];
				flags_next.n = sh_res[31];
				flags_next.z = (sh_res == 32'h0);
				flags_next.v = sh_ovf;
				flags_next.c = sh_carry;
			end
			OP_NONE: begin
				wb_next = '0;
			end
		endcase
	end

	// Result registers; results only ever reach general registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb <= '0;
		end else if (start) begin
			wb <= wb_next;
		end else begin
			wb <= '0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags <= '0;
		end else if (start && kind != OP_NONE) begin
			flags <= flags_next;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			done <= 1'b0;
			illegal_op <= 1'b0;
		end else begin
			done <= start && kind != OP_NONE;
			illegal_op <= start && kind == OP_NONE;
		end
	end

	// Checks
	sequence s_div_req;
		start && kind == OP_DIV;
	endsequence

	sequence s_mul_req;
		start && kind == OP_MUL;
	endsequence

	sequence s_ash_req;
		start && kind == OP_ASH;
	endsequence

	sequence s_double_word_shift_instr_req;
		start && kind == OP_DOUBLE_WORD_SHIFT_INSTR;
	endsequence

	sequence s_illegal_req;
		start && kind == OP_NONE;
	endsequence

	a_div_abort_nowrite: assert property (@(posedge clk) disable iff (!reset_n)
		s_div_req and div_ovf |=> !wb.hi_we && !wb.lo_we && flags.v)
		else $error("Aborted divide wrote a register");
	a_div_zero_c: assert property (@(posedge clk) disable iff (!reset_n)
		s_div_req |=> flags.c == $past(div_zero))
		else $error("Divide carry does not match zero divisor");
	a_div_rem_sign: assert property (@(posedge clk) disable iff (!reset_n)
		s_div_req and !div_ovf and rem_s != 16'h0000 |-> rem_s[15] == dividend[31])
		else $error("Remainder sign differs from dividend");
	a_mul_odd_low: assert property (@(posedge clk) disable iff (!reset_n)
		start && kind == OP_MUL && f.dest_reg_field[0] |=> wb.hi_we && !wb.lo_we)
		else $error("Odd multiply wrote the partner");
	a_mul_flags: assert property (@(posedge clk) disable iff (!reset_n)
		start && kind == OP_MUL |=> !flags.v && flags.n == $past(product[31]))
		else $error("Multiply flags wrong");
	a_shift_zero_cnt: assert property (@(posedge clk) disable iff (!reset_n)
		start && kind == OP_ASH && src_operand[5:0] == 6'h00 |=> wb.hi_data == $past(dest_value) && !flags.c)
		else $error("Zero shift changed the register");
	a_shift_right_v: assert property (@(posedge clk) disable iff (!reset_n)
		start && kind == OP_ASH && cnt_neg |=> !flags.v)
		else $error("Right shift set overflow");
	a_double_word_shift_instr_odd_one: assert property (@(posedge clk) disable iff (!reset_n)
		start && kind == OP_DOUBLE_WORD_SHIFT_INSTR && f.dest_reg_field[0] |=> !wb.lo_we)
		else $error("Odd double shift wrote two registers");
	a_done_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		start && kind != OP_NONE |=> done ##1 (done == $past(start && kind != OP_NONE)))
		else $error("Done not one cycle per request");
	a_illegal_pulse: assert property (@(posedge clk) disable iff (!reset_n)
		s_illegal_req |=> illegal_op && !done && wb == '0)
		else $error("Unknown opcode not refused");
	a_illegal_flags: assert property (@(posedge clk) disable iff (!reset_n)
		s_illegal_req |=> $stable(flags))
		else $error("Unknown opcode changed the flags");
	a_idle_no_write: assert property (@(posedge clk) disable iff (!reset_n)
		!start |=> wb == '0 && !done && !illegal_op)
		else $error("Write without a request");
	a_idle_flags_hold: assert property (@(posedge clk) disable iff (!reset_n)
		!start |=> $stable(flags))
		else $error("Flags moved without a request");
	a_field_dest_idx: assert property (@(posedge clk) disable iff (!reset_n)
		start && kind != OP_NONE |=> wb.hi_idx == $past(instr_word[8:6]))
		else $error("Destination field misplaced");
	a_mul_even_pair: assert property (@(posedge clk) disable iff (!reset_n)
		s_mul_req and !f.dest_reg_field[0] |=> wb.hi_we && wb.lo_we && {wb.hi_data, wb.lo_data} == $past(product))
		else $error("Even multiply pair wrong");
	a_mul_zero: assert property (@(posedge clk) disable iff (!reset_n)
		s_mul_req |=> flags.z == ($past(product) == 32'sh0))
		else $error("Multiply zero flag wrong");
	a_div_write_pair: assert property (@(posedge clk) disable iff (!reset_n)
		s_div_req and !div_ovf |=> wb.hi_we && wb.lo_we && wb.lo_idx == ($past(f.dest_reg_field) | 3'h1))
		else $error("Divide did not write the pair");
	a_div_nz_carry: assert property (@(posedge clk) disable iff (!reset_n)
		s_div_req and !div_zero |=> !flags.c)
		else $error("Divide carry set with nonzero divisor");
	a_div_neg_flag: assert property (@(posedge clk) disable iff (!reset_n)
		s_div_req |=> flags.n == $past(quo_s[15]))
		else $error("Divide negative flag wrong");
	a_ash_one_reg: assert property (@(posedge clk) disable iff (!reset_n)
		s_ash_req |=> wb.hi_we && !wb.lo_we)
		else $error("Single shift wrote the partner");
	a_ash_sign_n: assert property (@(posedge clk) disable iff (!reset_n)
		s_ash_req |=> flags.n == wb.hi_data[15])
		else $error("Single shift sign flag wrong");
	a_ash_zero_z: assert property (@(posedge clk) disable iff (!reset_n)
		s_ash_req |=> flags.z == (wb.hi_data == 16'h0000))
		else $error("Single shift zero flag wrong");
	a_double_word_shift_instr_even_two: assert property (@(posedge clk) disable iff (!reset_n)
		s_double_word_shift_instr_req and !f.dest_reg_field[0] |=> wb.hi_we && wb.lo_we)
		else $error("Even double shift missed a register");
	a_double_word_shift_instr_zero_z: assert property (@(posedge clk) disable iff (!reset_n)
		s_double_word_shift_instr_req and !f.dest_reg_field[0] |=> flags.z == ({wb.hi_data, wb.lo_data} == 32'h0))
		else $error("Double shift zero flag wrong");
	a_double_word_shift_instr_right_v: assert property (@(posedge clk) disable iff (!reset_n)
		s_double_word_shift_instr_req and cnt_neg |=> !flags.v)
		else $error("Double right shift set overflow");
	// A full sixteen place rotate must give back the word unchanged
	a_rot_full_turn: assert property (@(posedge clk) disable iff (!reset_n)
		s_double_word_shift_instr_req and f.dest_reg_field[0] and amt == 6'h10 and cnt_neg |=> wb.hi_data == $past(dest_value))
		else $error("Sixteen place rotate changed the word");
endmodule

// ---- dv/host_core_model.sv ----
// Host register file model that feeds and absorbs the unit
`timescale 1ns/100ps
module host_core_model
	import ext_arith_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Preload and register select
	input wire logic ld_en,
	input wire logic [2:0] ld_idx,
	input wire logic [15:0] ld_data,
	input wire logic [2:0] sel,
	// Unit side
	input wire writeback_t wb,
	output logic [15:0] dest_value,
	output logic [15:0] partner_value
);
	logic [15:0] rf_reg [8];
	assign dest_value = rf_reg[sel];
	assign partner_value = rf_reg[sel | 3'h1];
	// High half written after the low half so an odd register keeps the high write
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 8; i++) begin
				rf_reg[i] <= 16'h0000;
			end
		end else begin
			if (wb.lo_we)
				rf_reg[wb.lo_idx] <= wb.lo_data;
			if (wb.hi_we)
				rf_reg[wb.hi_idx] <= wb.hi_data;
			if (ld_en)
				rf_reg[ld_idx] <= ld_data;
		end
	end
endmodule

// ---- dv/ext_arith_unit_test.sv ----
// Self-checking bench for the extended integer arithmetic unit
`timescale 1ns/100ps
module ext_arith_unit_test
	import ext_arith_pkg::*;
;
	logic clk, reset_n, start, ld_en, pend, e_ill, wchk, done, illegal_op;
	logic [2:0] ld_idx, r;
	logic [6:0] o;
	logic [15:0] instr, src, ld_data, dv, pv, i, s;
	logic [3:0] fm;
	writeback_t wb, e_wb;
	flags_t flags, e_f, pf;
	int seed, bad_count, cmp_count;
	ext_arith_unit dut (.clk(clk), .reset_n(reset_n), .start(start), .instr_word(instr), .src_operand(src),
		.dest_value(dv), .partner_value(pv), .done(done), .illegal_op(illegal_op), .wb(wb), .flags(flags));
	host_core_model host (.clk(clk), .reset_n(reset_n), .ld_en(ld_en), .ld_idx(ld_idx), .ld_data(ld_data),
		.sel(instr[8:6]), .wb(wb), .dest_value(dv), .partner_value(pv));
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (e !== g) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task predict;
		logic signed [63:0] a, b, q, x, sx, f, u;
		int n, w;
		begin
			e_wb = '0;
			e_f = '0;
			fm = 4'hF;
			e_ill = 0;
			wchk = 1;
			e_wb.hi_idx = instr[8:6];
			e_wb.lo_idx = instr[8:6] | 3'h1;
			pf = flags;
			case (instr[15:9])
				7'h38: begin
					a = $signed(dv) * $signed(src);
					e_f = {a < 0, a == 0, 1'b0, (a < -32768) || (a >= 32767)};
					e_wb.hi_we = 1;
					e_wb.hi_data = instr[6] ? a[15:0] : a[31:16];
					e_wb.lo_we = !instr[6];
					e_wb.lo_data = a[15:0];
				end
				7'h39: begin
					a = $signed({dv, pv});
					b = $signed(src);
					if (b == 0) begin
						e_f = 4'h3;
						fm = 4'h3;
					end else begin
						q = a / b;
						e_f = {q[15], q[15:0] == 0, (q > 32767) || (q < -32768), 1'b0};
						a = a % b;
						e_wb.hi_we = !e_f.v;
						e_wb.lo_we = !e_f.v;
						e_wb.hi_data = q[15:0];
						e_wb.lo_data = a[15:0];
					end
				end
				7'h3A, 7'h3B: begin
					n = $signed(src[5:0]);
					w = instr[9] ? 32 : 16;
					x = instr[9] ? {dv, pv} : dv;
					sx = instr[9] ? $signed({dv, pv}) : $signed(dv);
					if (n >= 0) begin
						f = x << n;
						u = ((x << 32) >> (w + 31 - n)) & ((64'h1 << (n + 1)) - 1);
						e_f.c = f[w];
						e_f.v = f[w - 1] != x[w - 1];
						if ((u != 0 && u != (64'h1 << (n + 1)) - 1) != e_f.v)
							fm[1] = 0;
						if (n == 0) begin
							fm[0] = 0;
							wchk = 0;
						end
					end else begin
						f = sx >>> -n;
						e_f.c = sx[-n - 1];
						if (instr[9] && instr[6]) begin
							f = {dv, dv} >> -n;
							fm = 4'h3;
						end
					end
					e_f.n = f[w - 1];
					e_f.z = (instr[9] ? f[31:0] : f[15:0]) == 0;
					e_wb.hi_we = 1;
					e_wb.hi_data = (instr[9] && !(instr[6] && n < 0)) ? f[31:16] : f[15:0];
					e_wb.lo_we = instr[9] && !instr[6];
					e_wb.lo_data = f[15:0];
				end
				default: e_ill = 1;
			endcase
		end
	endtask
	task check_out;
		chk("illegal_op", e_ill, illegal_op);
		chk("done", !e_ill, done);
		if (e_ill)
			chk("flags kept", pf, flags);
		if (wchk)
			chk("write enables", {e_wb.hi_we, e_wb.lo_we}, {wb.hi_we, wb.lo_we});
		if (wb.hi_we === 1'b1)
			chk("hi write", {e_wb.hi_idx, e_wb.hi_data}, {wb.hi_idx, wb.hi_data});
		if (wb.lo_we === 1'b1)
			chk("lo write", {e_wb.lo_idx, e_wb.lo_data}, {wb.lo_idx, wb.lo_data});
		if (!e_ill)
			chk("flags", e_f & fm, flags & fm);
	endtask
	task op(input logic [15:0] ii, input logic [15:0] ss);
		@(negedge clk);
		if (pend)
			check_out;
		instr = ii;
		src = ss;
		start = 1;
		ld_en = 0;
		#1 predict;
		pend = 1;
	endtask
	task idle;
		@(negedge clk);
		if (pend)
			check_out;
		pend = 0;
		start = 0;
	endtask
	task ld(input logic [2:0] k, input logic [15:0] d);
		@(negedge clk);
		ld_en = 1;
		ld_idx = k;
		ld_data = d;
	endtask
	// Partner is loaded first, so for an odd register the dest word overwrites it
	task cs(input logic [15:0] d, input logic [15:0] p, input logic [6:0] oc, input logic [2:0] rr, input logic [15:0] ss);
		idle;
		ld(rr | 3'h1, p);
		ld(rr, d);
		op({oc, rr, 6'h00}, ss);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		summarize;
	end
	initial begin
		seed = 32'h0b538aae;
		{bad_count, cmp_count, pend, start, instr, src, ld_en, ld_idx, ld_data, reset_n} = '0;
		repeat (16) @(negedge clk);
		reset_n = 1;
		cs(16'h0100, 16'h0100, 7'h38, 3'h1, 16'h0008);
		cs(16'h7FFF, 16'h1234, 7'h38, 3'h2, 16'h7FFF);
		cs(16'h7FFF, 16'h0000, 7'h38, 3'h4, 16'h0001);
		cs(16'h0000, 16'h0001, 7'h39, 3'h0, 16'h0000);
		cs(16'h0001, 16'h0000, 7'h39, 3'h2, 16'h0001);
		cs(16'h0000, 16'h2001, 7'h39, 3'h4, 16'h0002);
		cs(16'hFFFF, 16'hFFF9, 7'h39, 3'h6, 16'h0002);
		cs(16'h4001, 16'h0000, 7'h3A, 3'h3, 16'h001F);
		cs(16'h8001, 16'h0000, 7'h3A, 3'h5, 16'h0020);
		cs(16'h1234, 16'h0000, 7'h3A, 3'h0, 16'h0000);
		cs(16'h8421, 16'h8421, 7'h3B, 3'h3, 16'h0030);
		cs(16'h8000, 16'h0001, 7'h3B, 3'h2, 16'h0020);
		cs(16'h0000, 16'h0000, 7'h3C, 3'h0, 16'h0000);
		idle;
		$display("test corner done");
		for (int k = 0; k < 8; k++)
			ld(k[2:0], $random(seed));
		repeat (400) begin
			o = 7'h38 + 7'({$random(seed)} % 5);
			r = $random(seed);
			s = $random(seed);
			i = $random(seed);
			if (o == 7'h39)
				r[0] = 0;
			if (o == 7'h3B && r[0] && s[5])
				s[5:4] = 2'h3;
			i[15:6] = {o, r};
			op(i, s);
		end
		idle;
		$display("test random done");
		summarize;
	end
endmodule
